// >>> hw/adcts_pkg.sv
package adcts_pkg;
    localparam int unsigned DIV_W = 6;
    localparam int unsigned SAMC_W = 5;
    localparam int unsigned SMPI_W = 4;
    localparam int unsigned CHPS_W = 2;
    localparam int unsigned SSRC_W = 3;
    localparam int unsigned CONV_TADS = 12;
    localparam logic [3:0] CONV_TADS_M1 = 4'hb;
    localparam logic [SSRC_W-1:0] SSRC_MANUAL = 3'h0;
    localparam logic [SSRC_W-1:0] SSRC_AUTO = 3'h7;
    // Register offsets (word index of the plain register port)
    localparam logic [3:0] OFF_CTRL1 = 4'h0;
    localparam logic [3:0] OFF_CTRL2 = 4'h1;
    localparam logic [3:0] OFF_CTRL3 = 4'h2;
    localparam logic [3:0] OFF_STAT = 4'h3;
    // Control one field positions
    localparam int unsigned C1_ON = 15;
    localparam int unsigned C1_SSRC = 5;
    localparam int unsigned C1_SIM = 3;
    localparam int unsigned C1_AUTO_SAMPLE_ENABLE = 2;
    localparam int unsigned C1_SAMPLE_BIT = 1;
    localparam int unsigned C1_DONE = 0;
    // Control two field positions
    localparam int unsigned C2_CHPS = 8;
    localparam int unsigned C2_SMPI = 2;
    // Control three field positions
    localparam int unsigned C3_SAMC = 8;
    localparam int unsigned C3_RC = 7;
    localparam int unsigned C3_DIV = 0;
    localparam logic [15:0] CTRL_RST = 16'h0000;
    localparam logic [SAMC_W-1:0] SAMC_RST = 5'h00;
    typedef enum logic [1:0] {
        ADCTS_IDLE,
        ADCTS_SAMPLE,
        ADCTS_CONVERT
    } adcts_state_t;
endpackage

// >>> hw/adcts_tick_if.sv
`timescale 1ns/1ns
`default_nettype none
interface adcts_tick_if;
    logic restart;
    logic [5:0] divisor;
    logic rc_sel;
    logic rc_tick;
    logic tick;
    modport gen (input restart, input divisor, input rc_sel, input rc_tick,
        output tick);
    modport use_side (output restart, output divisor, output rc_sel,
        output rc_tick, input tick);
endinterface
`default_nettype wire

// >>> hw/adcts_clkdiv.sv
`timescale 1ns/1ns
`default_nettype none
module adcts_clkdiv
    import adcts_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    adcts_tick_if.gen tk
);
    // Half-cycle count: period = (divisor+1) half instruction cycles,
    // so the enable rate is sys_clk/(divisor+1) with clk_sys as 2x INSTRUCTION_CYCLE_TIME.
    logic [DIV_W-1:0] cnt_r;
    logic [DIV_W-1:0] cnt_nxt;
    logic tick_r;
    logic tick_nxt;

    always_comb begin
        cnt_nxt = cnt_r;
        tick_nxt = 1'b0;
        if (tk.restart) begin
            cnt_nxt = '0;
        end else if (tk.rc_sel) begin
            tick_nxt = tk.rc_tick;
        end else if (cnt_r >= tk.divisor) begin
            cnt_nxt = '0;
            tick_nxt = 1'b1;
        end else begin
            cnt_nxt = cnt_r + 6'h01;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cnt_r <= '0;
            tick_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            tick_r <= tick_nxt;
        end
    end
    assign tk.tick = tick_r;

    div_period_a: assert property (@(posedge clk_sys) disable iff (rst)
        (tk.tick && !tk.rc_sel && tk.divisor == 6'h01
            && !tk.restart) |=> !tk.tick ##1 tk.tick || tk.restart
            || tk.rc_sel || $changed(tk.divisor))
        else $error("divider period wrong");
    div_restart_a: assert property (@(posedge clk_sys) disable iff (rst)
        tk.restart |=> !tk.tick)
        else $error("restart did not clear divider");
endmodule
`default_nettype wire

// >>> hw/adcts_seq.sv
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - Conversion takes twelve conversion clocks
// - Period is half-cycles times divisor plus one
// - RC select clocks from RC oscillator
// - Sampling timed by sample bit or automatically
// - Module off disables all sequencing logic
// - Sample time 2 holds two periods
// - Full sample phase precedes every conversion
// - Auto convert counts sample time, min one
// - Done after selected sequence count completes
// - Channel count picks one, two, four
// - Clearing module-on aborts, beats auto start
module adcts_seq
    import adcts_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire logic rc_osc_tick,
    output logic sample_active,
    output logic convert_active,
    output logic [1:0] hold_channel,
    output logic result_strobe,
    output logic conv_irq_flag
);
    adcts_state_t st_r, st_nxt;
    logic [15:0] c1_r, c1_nxt, c2_r, c2_nxt, c3_r, c3_nxt;
    logic [15:0] rdata_r, rdata_nxt;
    logic [3:0] tad_cnt_r, tad_cnt_nxt;
    logic [SAMC_W-1:0] smp_cnt_r, smp_cnt_nxt;
    logic [1:0] ch_r, ch_nxt;
    logic [SMPI_W-1:0] seq_cnt_r, seq_cnt_nxt;
    logic irq_r, irq_nxt;
    logic res_r, res_nxt;
    logic on_q_r;
    logic [9:0] conv_cyc_r, conv_cyc_nxt;

    adcts_tick_if tk ();
    adcts_clkdiv u_div (
        .clk_sys(clk_sys),
        .rst(rst),
        .tk(tk)
    );

    logic on;
    logic sample_bit_bit;
    logic auto_mode;
    logic [SAMC_W-1:0] samc;
    logic [1:0] last_ch;
    logic wr_c1;
    assign on = c1_r[C1_ON];
    assign sample_bit_bit = c1_r[C1_SAMPLE_BIT];
    assign auto_mode = c1_r[C1_SSRC +: SSRC_W] == SSRC_AUTO;
    assign samc = c3_r[C3_SAMC +: SAMC_W];
    assign wr_c1 = reg_wr && reg_addr == OFF_CTRL1;
    // Restart on the rising edge of module-on and while it is off
    assign tk.restart = !on || !on_q_r;
    assign tk.divisor = c3_r[C3_DIV +: DIV_W];
    assign tk.rc_sel = c3_r[C3_RC];
    assign tk.rc_tick = rc_osc_tick;

    function automatic logic [1:0] chan_last(input logic [1:0] chps);
        // 00: CH0 only, 01: CH0..1, 1x: CH0..3
        case (chps)
            2'h0: chan_last = 2'h0;
            2'h1: chan_last = 2'h1;
            default: chan_last = 2'h3;
        endcase
    endfunction
    assign last_ch = chan_last(c2_r[C2_CHPS +: CHPS_W]);

    // One less than the clock cycles that twelve conversion clock periods span
    function automatic logic [9:0] conv_span(input logic [5:0] dv);
        conv_span = 10'(CONV_TADS * ({26'h0, dv} + 32'h1) - 32'h1);
    endfunction

    always_comb begin
        st_nxt = st_r;
        c1_nxt = c1_r;
        c2_nxt = c2_r;
        c3_nxt = c3_r;
        tad_cnt_nxt = tad_cnt_r;
        smp_cnt_nxt = smp_cnt_r;
        ch_nxt = ch_r;
        seq_cnt_nxt = seq_cnt_r;
        irq_nxt = irq_r;
        res_nxt = 1'b0;
        rdata_nxt = 16'h0000;
        if (reg_wr) begin
            case (reg_addr)
                OFF_CTRL1: c1_nxt = reg_wdata;
                OFF_CTRL2: c2_nxt = reg_wdata;
                OFF_CTRL3: c3_nxt = reg_wdata;
                OFF_STAT: irq_nxt = irq_r & ~reg_wdata[0];
                default: ;
            endcase
        end
        if (reg_rd) begin
            case (reg_addr)
                OFF_CTRL1: rdata_nxt = c1_r;
                OFF_CTRL2: rdata_nxt = c2_r;
                OFF_CTRL3: rdata_nxt = c3_r;
                OFF_STAT: rdata_nxt = {12'h000, ch_r, st_r != ADCTS_IDLE,
                    irq_r};
                default: rdata_nxt = 16'h0000;
            endcase
        end
        case (st_r)
            ADCTS_IDLE: begin
                // Sample phase always precedes conversion
                if (on && (sample_bit_bit || c1_r[C1_AUTO_SAMPLE_ENABLE])) begin
                    st_nxt = ADCTS_SAMPLE;
                    smp_cnt_nxt = '0;
                    if (!sample_bit_bit) begin
                        c1_nxt[C1_SAMPLE_BIT] = 1'b1;
                    end
                end
            end
            ADCTS_SAMPLE: begin
                if (auto_mode) begin
                    if (tk.tick) begin
                        // Zero sample time is treated as one period
                        if (smp_cnt_r + 5'h01 >= samc) begin
                            st_nxt = ADCTS_CONVERT;
                            tad_cnt_nxt = '0;
                            c1_nxt[C1_SAMPLE_BIT] = 1'b0;
                        end else begin
                            smp_cnt_nxt = smp_cnt_r + 5'h01;
                        end
                    end
                end else if (!sample_bit_bit && tk.tick) begin
                    st_nxt = ADCTS_CONVERT;
                    tad_cnt_nxt = '0;
                end
            end
            ADCTS_CONVERT: begin
                if (tk.tick) begin
                    if (tad_cnt_r == CONV_TADS_M1) begin
                        res_nxt = 1'b1;
                        st_nxt = ADCTS_IDLE;
                        if (ch_r == last_ch) begin
                            ch_nxt = 2'h0;
                            if (seq_cnt_r == c2_r[C2_SMPI +: SMPI_W]) begin
                                seq_cnt_nxt = '0;
                                irq_nxt = 1'b1;
                                c1_nxt[C1_DONE] = 1'b1;
                            end else begin
                                seq_cnt_nxt = seq_cnt_r + 4'h1;
                            end
                        end else begin
                            ch_nxt = ch_r + 2'h1;
                        end
                    end else begin
                        tad_cnt_nxt = tad_cnt_r + 4'h1;
                    end
                end
            end
            default: st_nxt = ADCTS_IDLE;
        endcase
        if (wr_c1 && reg_wdata[C1_SAMPLE_BIT] && !reg_wdata[C1_DONE]
                && !c1_r[C1_DONE]) begin
            c1_nxt[C1_DONE] = 1'b0;
        end
        if (!on) begin
            // Off overrides any coincident auto start; no result
            st_nxt = ADCTS_IDLE;
            res_nxt = 1'b0;
            ch_nxt = 2'h0;
            seq_cnt_nxt = '0;
            tad_cnt_nxt = '0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st_r <= ADCTS_IDLE;
            c1_r <= CTRL_RST;
            c2_r <= CTRL_RST;
            c3_r <= CTRL_RST;
            rdata_r <= 16'h0000;
            tad_cnt_r <= '0;
            smp_cnt_r <= SAMC_RST;
            ch_r <= 2'h0;
            seq_cnt_r <= '0;
            irq_r <= 1'b0;
            res_r <= 1'b0;
            on_q_r <= 1'b0;
            sample_active <= 1'b0;
            convert_active <= 1'b0;
            hold_channel <= 2'h0;
        end else begin
            st_r <= st_nxt;
            c1_r <= c1_nxt;
            c2_r <= c2_nxt;
            c3_r <= c3_nxt;
            rdata_r <= rdata_nxt;
            tad_cnt_r <= tad_cnt_nxt;
            smp_cnt_r <= smp_cnt_nxt;
            ch_r <= ch_nxt;
            seq_cnt_r <= seq_cnt_nxt;
            irq_r <= irq_nxt;
            res_r <= res_nxt;
            on_q_r <= on;
            sample_active <= st_nxt == ADCTS_SAMPLE;
            convert_active <= st_nxt == ADCTS_CONVERT;
            hold_channel <= ch_nxt;
        end
    end
    assign reg_rdata = rdata_r;
    assign result_strobe = res_r;
    assign conv_irq_flag = irq_r;

    // Helper count for the length check; a long repetition would not unroll
    always_comb begin
        conv_cyc_nxt = 10'h000;
        if (st_r == ADCTS_CONVERT) begin
            conv_cyc_nxt = conv_cyc_r + 10'h001;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            conv_cyc_r <= 10'h000;
        end else begin
            conv_cyc_r <= conv_cyc_nxt;
        end
    end

    sequence conv_end_s;
        st_r == ADCTS_CONVERT && st_nxt == ADCTS_IDLE && on && !tk.rc_sel
            && $stable(c3_r);
    endsequence
    conv_len_a: assert property (
        @(posedge clk_sys) disable iff (rst)
        conv_end_s |-> conv_cyc_r == conv_span(tk.divisor))
        else $error("conversion length wrong");
    off_idle_a: assert property (@(posedge clk_sys) disable iff (rst)
        !on |=> st_r == ADCTS_IDLE && !result_strobe)
        else $error("module off but sequencing");
    abort_a: assert property (@(posedge clk_sys) disable iff (rst)
        (st_r == ADCTS_CONVERT && !on) |=> !res_r)
        else $error("aborted conversion produced result");
    sample_bit_first_a: assert property (@(posedge clk_sys) disable iff (rst)
        (st_r == ADCTS_IDLE && st_nxt != ADCTS_IDLE)
        |-> st_nxt == ADCTS_SAMPLE)
        else $error("conversion without sample phase");
    auto_len_a: assert property (@(posedge clk_sys) disable iff (rst)
        (st_r == ADCTS_SAMPLE && auto_mode && st_nxt == ADCTS_CONVERT)
        |-> tk.tick && (smp_cnt_r + 5'h01 >= samc))
        else $error("auto sample ended early");
    manual_a: assert property (@(posedge clk_sys) disable iff (rst)
        (st_r == ADCTS_SAMPLE && !auto_mode && sample_bit_bit && on)
        |=> st_r == ADCTS_SAMPLE)
        else $error("manual sample ended while sample bit set");
    done_a: assert property (@(posedge clk_sys) disable iff (rst)
        $rose(irq_r) |-> $past(ch_r) == $past(last_ch)
            && $past(seq_cnt_r) == $past(c2_r[C2_SMPI +: SMPI_W]))
        else $error("done raised before sequence count");
    chan_a: assert property (@(posedge clk_sys) disable iff (rst)
        ch_r <= last_ch || $changed(c2_r))
        else $error("channel beyond selected count");
    rc_a: assert property (@(posedge clk_sys) disable iff (rst)
        (tk.rc_sel && on && on_q_r && !rc_osc_tick) |=> !tk.tick)
        else $error("tick without rc oscillator");

    res_pulse_a: assert property (
        @(posedge clk_sys) disable iff (rst)
        result_strobe |=> !result_strobe)
        else $error("result strobe longer than one cycle");
    sample_bit_out_a: assert property (
        @(posedge clk_sys) disable iff (rst)
        sample_active == (st_r == ADCTS_SAMPLE))
        else $error("sample output disagrees with state");
    conv_out_a: assert property (
        @(posedge clk_sys) disable iff (rst)
        convert_active == (st_r == ADCTS_CONVERT))
        else $error("convert output disagrees with state");
    hold_out_a: assert property (
        @(posedge clk_sys) disable iff (rst)
        hold_channel == ch_r)
        else $error("hold channel output disagrees");
    irq_hold_a: assert property (
        @(posedge clk_sys) disable iff (rst)
        irq_r && !(reg_wr && reg_addr == OFF_STAT && reg_wdata[0])
        |=> irq_r)
        else $error("interrupt flag dropped without clear");
    // Set must win over a clear that lands in the same cycle
    irq_set_a: assert property (
        @(posedge clk_sys) disable iff (rst)
        (st_r == ADCTS_CONVERT && tk.tick && on
            && tad_cnt_r == CONV_TADS_M1 && ch_r == last_ch
            && seq_cnt_r == c2_r[C2_SMPI +: SMPI_W])
        |=> irq_r)
        else $error("interrupt flag not raised after sequence");
    off_tick_a: assert property (
        @(posedge clk_sys) disable iff (rst)
        !on |=> !tk.tick)
        else $error("conversion clock running while off");
endmodule
`default_nettype wire

// >>> testbench/adcts_seq_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module adcts_seq_tb_top;
    import adcts_pkg::*;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic rc_osc_tick = 1'b0;
    logic [15:0] reg_rdata;
    logic sample_active;
    logic convert_active;
    logic [1:0] hold_channel;
    logic result_strobe;
    logic conv_irq_flag;
    int err_count = 0;
    int checks = 0;
    int rc_div = 0;
    int rc_cnt = 0;
    logic [31:0] lfsr_st = 32'h4302def6;

    adcts_seq adcts_seq_inst (
        .clk_sys(clk_sys),
        .rst(rst),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .rc_osc_tick(rc_osc_tick),
        .sample_active(sample_active),
        .convert_active(convert_active),
        .hold_channel(hold_channel),
        .result_strobe(result_strobe),
        .conv_irq_flag(conv_irq_flag)
    );

    always #4 clk_sys = ~clk_sys;

    // Stand-in RC oscillator: one pulse every rc_div cycles
    always @(posedge clk_sys) begin
        rc_cnt <= (rc_div != 0 && rc_cnt < rc_div - 1) ? rc_cnt + 1 : 0;
        rc_osc_tick <= (rc_div != 0 && rc_cnt == rc_div - 1);
    end

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Model: strobe spacing in auto mode, sample time zero acts as one
    function automatic int period(input int sc, input int unit);
        return ((sc == 0 ? 1 : sc) + CONV_TADS) * unit;
    endfunction

    task automatic tally_and_finish();
        $display("checks %0d err_count %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
        input string what);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t %s seen %0h exp %0h", $time, what,
                seen, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    // Module is switched off first: fields may not change while running
    task automatic cfg(input logic [1:0] cp, input logic [3:0] sp,
        input logic [4:0] sc, input logic rc, input logic [5:0] dv);
        logic [15:0] v2;
        logic [15:0] v3;
        v2 = 16'h0000;
        v3 = 16'h0000;
        v2[C2_CHPS +: CHPS_W] = cp;
        v2[C2_SMPI +: SMPI_W] = sp;
        v3[C3_SAMC +: SAMC_W] = sc;
        v3[C3_RC] = rc;
        v3[C3_DIV +: DIV_W] = dv;
        wr(OFF_CTRL1, 16'h0000);
        wr(OFF_STAT, 16'h0001);
        wr(OFF_CTRL2, v2);
        wr(OFF_CTRL3, v3);
    endtask

    task automatic on_ctrl(input logic [2:0] src, input logic auto_sample_enable,
        input logic sample_bit);
        logic [15:0] v;
        v = 16'h0000;
        v[C1_ON] = 1'b1;
        v[C1_SSRC +: SSRC_W] = src;
        // Let the converter settle before any sampling starts
        wr(OFF_CTRL1, v);
        repeat (8) @(posedge clk_sys);
        v[C1_AUTO_SAMPLE_ENABLE] = auto_sample_enable;
        v[C1_SAMPLE_BIT] = sample_bit;
        wr(OFF_CTRL1, v);
    endtask

    // Channel is the one seen during the last converting cycle
    task automatic next_strobe(output int n, output logic [1:0] ch);
        n = 0;
        ch = 2'h0;
        do begin
            @(posedge clk_sys);
            n++;
            if (convert_active === 1'b1) ch = hold_channel;
        end while (result_strobe !== 1'b1 && n < 4000);
        check(n < 4000, 1, "strobe wait");
    endtask

    initial begin
        #(8 * 60000);
        err_count++;
        tally_and_finish();
    end

    initial begin
        logic [15:0] d;
        logic [1:0] ch;
        int n;
        int k;
        int dv;
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        wr(4'h9, 16'hffff);
        for (int a = 0; a < 5; a++) begin
            rd(a[3:0] + ((a == 4) ? 4'h5 : 4'h0), d);
            check(d, 0, "reset or unmapped read");
        end
        for (int i = 0; i < 4; i++) begin
            lfsr_st = lfsr_next(lfsr_st);
            dv = 10 + int'(lfsr_st[2:0]);
            cfg(2'h0, 4'h0, 5'(i), 1'b0, 6'(dv));
            on_ctrl(SSRC_AUTO, 1'b1, 1'b0);
            next_strobe(n, ch);
            next_strobe(n, ch);
            check(n, period(i, dv + 1), "auto period");
        end
        cfg(2'h0, 4'h0, 5'h02, 1'b1, 6'h3f);
        rc_div = 5;
        on_ctrl(SSRC_AUTO, 1'b1, 1'b0);
        next_strobe(n, ch);
        next_strobe(n, ch);
        check(n, period(2, 5), "rc period");
        cfg(2'h0, 4'h0, 5'h01, 1'b0, 6'h0a);
        rc_div = 0;
        on_ctrl(SSRC_MANUAL, 1'b0, 1'b1);
        repeat (20) @(posedge clk_sys);
        check({sample_active, convert_active}, 2'b10, "manual hold");
        wr(OFF_CTRL1, 16'h0001 << C1_ON);
        n = 0;
        k = 0;
        while (convert_active !== 1'b1 && k < 100) begin
            @(posedge clk_sys);
            k++;
        end
        while (convert_active === 1'b1 && n < 1000) begin
            @(posedge clk_sys);
            n++;
        end
        check(n, CONV_TADS * 11, "convert length");
        repeat (30) @(posedge clk_sys);
        check({sample_active, conv_irq_flag}, 2'b01, "manual end");
        cfg(2'h0, 4'h3, 5'h01, 1'b0, 6'h0a);
        on_ctrl(SSRC_AUTO, 1'b1, 1'b0);
        for (k = 1; k <= 4; k++) begin
            next_strobe(n, ch);
            repeat (2) @(posedge clk_sys);
            check(conv_irq_flag, k == 4, "irq count");
        end
        rd(OFF_STAT, d);
        check(d[0], 1'b1, "irq status");
        cfg(2'h0, 4'h0, 5'h01, 1'b0, 6'h00);
        rd(OFF_STAT, d);
        check(d[1:0], 2'b00, "irq cleared");
        for (int cp = 0; cp < 3; cp++) begin
            cfg(2'(cp), 4'(cp != 0), 5'h01, 1'b0, 6'h0a);
            on_ctrl(SSRC_AUTO, 1'b1, 1'b0);
            for (k = 0; k < 5; k++) begin
                next_strobe(n, ch);
                check(ch, k % (1 << cp), "hold channel");
            end
        end
        cfg(2'h0, 4'h0, 5'h01, 1'b0, 6'h0a);
        on_ctrl(SSRC_AUTO, 1'b1, 1'b0);
        k = 0;
        while (convert_active !== 1'b1 && k < 200) begin
            @(posedge clk_sys);
            k++;
        end
        repeat (20) @(posedge clk_sys);
        wr(OFF_CTRL1, 16'h0000);
        repeat (3) @(posedge clk_sys);
        check({sample_active, convert_active}, 2'b00, "abort");
        k = 0;
        repeat (200) begin
            @(posedge clk_sys);
            if (result_strobe === 1'b1) k++;
        end
        check(k, 0, "no result after abort");
        tally_and_finish();
    end
endmodule
`default_nettype wire
